/* epsp_chk.sv */
`timescale 1ns/10ps
// Purpose: link checker beside the interface joining both ends
// Assumes: one clk domain, synchronous active-high reset
// Notes: sda holds are judged in every high cycle of sclk after the first
module epsp_chk (
    // clock, reset and strap
    input wire logic clk,
    input wire logic reset,
    input wire logic bus_mode_strap,
    // link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dc,
    input wire logic reset_n_pin,
    input wire logic busy,
    input wire logic host_sda_out,
    input wire logic host_sda_oe,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    // select, reset and data/command pin discipline
    property p_idle_quiet;
        cs_n [*5] |-> !dev_sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven idle");
    property p_reset_quiet;
        !reset_n_pin [*6] |-> !busy && !dev_sda_oe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("active in reset");
    property p_dc_3w;
        bus_mode_strap |-> !dc;
    endproperty
    a_dc_3w: assert property (p_dc_3w) else $error("dc not low");
    property p_dc_steady;
        !cs_n && sclk |-> $stable(dc);
    endproperty
    a_dc_steady: assert property (p_dc_steady) else $error("dc moved");
    // a bit may only move while sclk is low
    property p_host_hold;
        host_sda_oe && sclk && $past(sclk) |-> $stable(host_sda_out);
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("host bit moved");
    property p_dev_hold;
        dev_sda_oe && sclk && $past(sclk) |-> $stable(dev_sda_out);
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device bit moved");
    property p_one_drv;
        !(dev_sda_oe && host_sda_oe);
    endproperty
    a_one_drv: assert property (p_one_drv) else $error("sda contention");
    property p_release;
        $rose(cs_n) |-> ##[1:5] !dev_sda_oe;
    endproperty
    a_release: assert property (p_release) else $error("sda kept");
endmodule

/* epsp_device.sv */
`timescale 1ns/10ps
// Purpose: device end of the e-paper serial port: receive, route, read back
// Assumes: link pins are asynchronous; serial clock well below clk/4
// Notes: received bytes queue in a FIFO; a full FIFO raises busy
module epsp_device (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // link and board strap
    epsp_if.dev             link,
    input  wire logic       bus_mode_strap,
    // received bytes
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic [7:0]      rx_data,
    output logic            rx_is_data,
    // command and read-back
    output logic [7:0]      last_cmd,
    input  wire logic       read_cmd,
    input  wire logic [7:0] tx_data,
    output logic            tx_next,
    // status
    input  wire logic       busy_in,
    output logic            overflow,
    input  wire logic       overflow_clr,
    output logic            in_reset
);
    import epsp_pkg::*;

    typedef enum logic [1:0] {EPSP_RX, EPSP_RDFLAG, EPSP_RD} epsp_dstate_t;

    logic [5:0]   pin_meta;
    logic [5:0]   pin_sync;
    logic         sclk_prev;
    logic         core_rst;
    logic         mode3;
    epsp_dstate_t state;
    epsp_dstate_t next_state;
    logic [3:0]   bit_cnt;
    logic [3:0]   next_bit_cnt;
    logic [8:0]   shreg;
    logic [8:0]   next_shreg;
    logic         cmd_pending;
    logic         next_cmd_pending;
    logic [7:0]   tx_sh;
    logic [7:0]   next_tx_sh;
    logic [2:0]   tx_cnt;
    logic [2:0]   next_tx_cnt;
    logic         sda_out;
    logic         next_sda_out;
    logic         sda_oe;
    logic         next_sda_oe;
    logic [7:0]   next_last_cmd;
    logic         next_tx_next;
    logic         push;
    logic         next_push;
    logic [8:0]   push_data;
    logic [8:0]   next_push_data;
    logic         fifo_ready;
    logic [8:0]   fifo_out;
    logic         busy;
    logic         sclk_s;
    logic         cs_n_s;
    logic         dc_s;
    logic         sda_s;
    logic         rise;
    logic         fall;
    logic [8:0]   word_in;
    logic [3:0]   nbits;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; only the second stage is read by logic
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta <= PIN_RESET;
            pin_sync <= PIN_RESET;
        end else begin
            pin_meta <= {link.sclk, link.cs_n, link.dc, link.sda, link.reset_n_pin,
                         bus_mode_strap};
            pin_sync <= pin_meta;
        end
    end

    assign sclk_s   = pin_sync[5];
    assign cs_n_s   = pin_sync[4];
    assign dc_s     = pin_sync[3];
    assign sda_s    = pin_sync[2];
    assign core_rst = reset || !pin_sync[1];
    assign rise     = sclk_s && !sclk_prev;
    assign fall     = !sclk_s && sclk_prev;
    assign word_in  = {shreg[7:0], sda_s};
    assign nbits    = mode3 ? BITS_3WIRE : BITS_4WIRE;

    // strap is caught while held in reset, so it cannot change mid-traffic
    always_ff @(posedge clk) begin
        if (core_rst) begin
            mode3 <= pin_sync[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive and read-back sequencer
    always_comb begin
        next_state       = state;
        next_bit_cnt     = bit_cnt;
        next_shreg       = shreg;
        next_cmd_pending = cmd_pending;
        next_tx_sh       = tx_sh;
        next_tx_cnt      = tx_cnt;
        next_sda_out     = sda_out;
        next_sda_oe      = sda_oe;
        next_last_cmd    = last_cmd;
        next_tx_next     = 1'b0;
        next_push        = 1'b0;
        next_push_data   = push_data;
        if (cs_n_s) begin
            // deselected: drop partial word and release the data line
            next_state       = EPSP_RX;
            next_bit_cnt     = 4'h0;
            next_cmd_pending = 1'b0;
            next_tx_cnt      = 3'h0;
            next_sda_oe      = 1'b0;
        end else begin
            case (state)
                EPSP_RX: begin
                    if (rise) begin
                        next_shreg       = word_in;
                        next_cmd_pending = 1'b0;
                        if (bit_cnt == nbits - 4'h1) begin
                            next_bit_cnt   = 4'h0;
                            next_push      = 1'b1;
                            // flag is the first bit in 3-wire, the pin in 4-wire
                            next_push_data = {mode3 ? word_in[8] : dc_s, word_in[7:0]};
                            if (!next_push_data[8]) begin
                                next_last_cmd    = word_in[7:0];
                                next_cmd_pending = 1'b1;
                            end
                        end else begin
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end else if (fall && cmd_pending) begin
                        next_cmd_pending = 1'b0;
                        if (read_cmd && mode3) begin
                            next_state = EPSP_RDFLAG;
                        end else if (read_cmd) begin
                            // first result bit leaves on the fall after the command
                            next_state   = EPSP_RD;
                            next_tx_sh   = {tx_data[6:0], 1'b0};
                            next_sda_out = tx_data[7];
                            next_sda_oe  = 1'b1;
                            next_tx_cnt  = 3'h7;
                            next_tx_next = 1'b1;
                        end
                    end
                end
                EPSP_RDFLAG: begin
                    // the single flag-one clock is consumed without storing
                    if (rise) begin
                        next_state = EPSP_RD;
                    end
                end
                EPSP_RD: begin
                    if (fall) begin
                        next_sda_oe = 1'b1;
                        if (tx_cnt == 3'h0) begin
                            next_tx_sh   = {tx_data[6:0], 1'b0};
                            next_sda_out = tx_data[7];
                            next_tx_cnt  = 3'h7;
                            next_tx_next = 1'b1;
                        end else begin
                            next_tx_sh   = {tx_sh[6:0], 1'b0};
                            next_sda_out = tx_sh[7];
                            next_tx_cnt  = tx_cnt - 3'h1;
                        end
                    end
                end
                default: begin
                    next_state = EPSP_RX;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            state       <= EPSP_RX;
            bit_cnt     <= 4'h0;
            shreg       <= 9'h000;
            cmd_pending <= 1'b0;
            tx_sh       <= 8'h00;
            tx_cnt      <= 3'h0;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
            last_cmd    <= 8'h00;
            tx_next     <= 1'b0;
            push        <= 1'b0;
            push_data   <= 9'h000;
            sclk_prev   <= 1'b0;
        end else begin
            state       <= next_state;
            bit_cnt     <= next_bit_cnt;
            shreg       <= next_shreg;
            cmd_pending <= next_cmd_pending;
            tx_sh       <= next_tx_sh;
            tx_cnt      <= next_tx_cnt;
            sda_out     <= next_sda_out;
            sda_oe      <= next_sda_oe;
            last_cmd    <= next_last_cmd;
            tx_next     <= next_tx_next;
            push        <= next_push;
            push_data   <= next_push_data;
            sclk_prev   <= sclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte queue; the link cannot stall, so a full queue shows as busy
    epsp_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (core_rst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (fifo_out)
    );

    assign rx_data    = fifo_out[7:0];
    assign rx_is_data = fifo_out[8];

    // status flags; a new overflow wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (core_rst) begin
            busy     <= 1'b0;
            overflow <= 1'b0;
            in_reset <= 1'b1;
        end else begin
            busy     <= busy_in || !fifo_ready;
            overflow <= (push && !fifo_ready) || (overflow && !overflow_clr);
            in_reset <= 1'b0;
        end
    end

    assign link.busy        = busy;
    assign link.dev_sda_out = sda_out;
    assign link.dev_sda_oe  = sda_oe;
endmodule

/* epsp_fifo.sv */
`timescale 1ns/10ps
// Purpose: small synchronous FIFO for received bytes
// Assumes: single clock, synchronous active-high reset
// Notes: depth must be a power of two
module epsp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;

    // full when pointers differ only in the wrap bit
    assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // pointer advance
    always_comb begin
        next_wr_ptr = wr_ptr + ((in_valid && in_ready) ? 1'b1 : 1'b0);
        next_rd_ptr = rd_ptr + ((out_valid && out_ready) ? 1'b1 : 1'b0);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage has no reset; only written entries are ever read
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

/* epsp_host.sv */
`timescale 1ns/10ps
// Purpose: host end: drives select, clock, data/command and reset pins
// Assumes: device busy is asynchronous; 3-wire mode mirrors the strap
// Notes: serial clock is clk divided by twice HALF_CLKS
module epsp_host #(
    parameter int HALF = epsp_pkg::HALF_CLKS
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // link
    epsp_if.host            link,
    // command side
    input  wire logic       mode3,
    input  wire logic       reset_req,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire logic       cmd_is_data,
    input  wire logic [7:0] cmd_byte,
    input  wire logic [3:0] rd_count,
    // read results
    output logic            rd_valid,
    output logic [7:0]      rd_byte
);
    import epsp_pkg::*;

    typedef enum logic [2:0] {EPSH_IDLE, EPSH_LOW, EPSH_HIGH, EPSH_END, EPSH_GAP} epsh_state_t;
    typedef enum logic [1:0] {EPSH_WR, EPSH_FLAG, EPSH_RD} epsh_phase_t;

    logic [1:0]  in_meta;
    logic [1:0]  in_sync;
    logic [7:0]  div;
    logic        tick;
    epsh_state_t state;
    epsh_state_t next_state;
    epsh_phase_t phase;
    epsh_phase_t next_phase;
    logic [3:0]  bit_cnt;
    logic [3:0]  next_bit_cnt;
    logic [8:0]  sh;
    logic [8:0]  next_sh;
    logic [3:0]  rd_left;
    logic [3:0]  next_rd_left;
    logic [7:0]  rx_sh;
    logic [7:0]  next_rx_sh;
    logic        sclk;
    logic        next_sclk;
    logic        cs_n;
    logic        next_cs_n;
    logic        dc;
    logic        next_dc;
    logic        sda_oe;
    logic        next_sda_oe;
    logic        next_cmd_ready;
    logic        next_rd_valid;
    logic [7:0]  next_rd_byte;
    logic        reset_n_pin;

    ////////////////////////////////////////////////////////////////////////////
    // synchronise busy and data; half-period tick divider
    always_ff @(posedge clk) begin
        if (reset) begin
            in_meta <= 2'h0;
            in_sync <= 2'h0;
            div     <= 8'h00;
            tick    <= 1'b0;
        end else begin
            in_meta <= {link.busy, link.sda};
            in_sync <= in_meta;
            div     <= (div == 8'(HALF - 1)) ? 8'h00 : div + 8'h01;
            tick    <= (div == 8'(HALF - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencer
    always_comb begin
        next_state     = state;
        next_phase     = phase;
        next_bit_cnt   = bit_cnt;
        next_sh        = sh;
        next_rd_left   = rd_left;
        next_rx_sh     = rx_sh;
        next_sclk      = sclk;
        next_cs_n      = cs_n;
        next_dc        = dc;
        next_sda_oe    = sda_oe;
        next_rd_valid  = 1'b0;
        next_rd_byte   = rd_byte;
        case (state)
            EPSH_IDLE: begin
                if (cmd_valid && cmd_ready) begin
                    // a read always starts with a command byte
                    next_cs_n    = 1'b0;
                    next_phase   = EPSH_WR;
                    next_dc      = !mode3 && cmd_is_data && (rd_count == 4'h0);
                    next_sh      = {cmd_is_data && (rd_count == 4'h0), cmd_byte};
                    next_bit_cnt = mode3 ? BITS_3WIRE - 4'h1 : BITS_4WIRE - 4'h1;
                    next_rd_left = rd_count;
                    next_sda_oe  = 1'b1;
                    next_state   = EPSH_LOW;
                end
            end
            EPSH_LOW: begin
                if (tick) begin
                    next_sclk  = 1'b1;
                    next_state = EPSH_HIGH;
                end
            end
            EPSH_HIGH: begin
                if (tick) begin
                    next_sclk  = 1'b0;
                    next_state = EPSH_LOW;
                    next_rx_sh = {rx_sh[6:0], in_sync[0]};
                    if (bit_cnt != 4'h0) begin
                        next_bit_cnt = bit_cnt - 4'h1;
                    end else if (phase == EPSH_RD) begin
                        next_rd_valid = 1'b1;
                        next_rd_byte  = {rx_sh[6:0], in_sync[0]};
                        next_rd_left  = rd_left - 4'h1;
                        next_bit_cnt  = 4'h7;
                        if (rd_left == 4'h1) begin
                            next_state = EPSH_END;
                        end
                    end else if (rd_left == 4'h0) begin
                        next_state = EPSH_END;
                    end else if (phase == EPSH_WR && mode3) begin
                        next_phase   = EPSH_FLAG;
                        next_sh      = 9'h001;
                        next_bit_cnt = 4'h0;
                    end else begin
                        next_phase   = EPSH_RD;
                        next_dc      = !mode3;
                        next_sda_oe  = 1'b0;
                        next_bit_cnt = 4'h7;
                    end
                end
            end
            EPSH_END: begin
                if (tick) begin
                    next_cs_n    = 1'b1;
                    next_dc      = 1'b0;
                    next_sda_oe  = 1'b0;
                    next_bit_cnt = 4'(GAP_TICKS);
                    next_state   = EPSH_GAP;
                end
            end
            EPSH_GAP: begin
                // keeps select high long enough between transfers
                if (tick) begin
                    if (bit_cnt == 4'h0) begin
                        next_state = EPSH_IDLE;
                    end else begin
                        next_bit_cnt = bit_cnt - 4'h1;
                    end
                end
            end
            default: begin
                next_state = EPSH_IDLE;
            end
        endcase
        // never start while the device reports busy
        next_cmd_ready = (next_state == EPSH_IDLE) && !in_sync[1] && !reset_req;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state       <= EPSH_IDLE;
            phase       <= EPSH_WR;
            bit_cnt     <= 4'h0;
            sh          <= 9'h000;
            rd_left     <= 4'h0;
            rx_sh       <= 8'h00;
            sclk        <= 1'b0;
            cs_n        <= 1'b1;
            dc          <= 1'b0;
            sda_oe      <= 1'b0;
            cmd_ready   <= 1'b0;
            rd_valid    <= 1'b0;
            rd_byte     <= 8'h00;
            reset_n_pin <= 1'b0;
        end else begin
            state       <= next_state;
            phase       <= next_phase;
            bit_cnt     <= next_bit_cnt;
            sh          <= next_sh;
            rd_left     <= next_rd_left;
            rx_sh       <= next_rx_sh;
            sclk        <= next_sclk;
            cs_n        <= next_cs_n;
            dc          <= next_dc;
            sda_oe      <= next_sda_oe;
            cmd_ready   <= next_cmd_ready;
            rd_valid    <= next_rd_valid;
            rd_byte     <= next_rd_byte;
            reset_n_pin <= !reset_req;
        end
    end

    // the link rate is fixed by HALF; keep it within the read limit
    assign link.sclk         = sclk;
    assign link.cs_n         = cs_n;
    assign link.dc           = dc;
    assign link.reset_n_pin  = reset_n_pin;
    assign link.host_sda_out = sh[bit_cnt];
    assign link.host_sda_oe  = sda_oe;
endmodule

/* epsp_if.sv */
`timescale 1ns/10ps
// Purpose: serial link between host and e-paper device ends
// Assumes: data line has a weak pull-up when nobody drives it
// Notes: no tri-state here; the shared level is resolved from enables
interface epsp_if;
    logic sclk;
    logic cs_n;
    logic dc;
    logic reset_n_pin;
    logic busy;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic sda;

    // resolved data line, pulled high when idle
    assign sda = dev_sda_oe ? dev_sda_out : (host_sda_oe ? host_sda_out : 1'b1);

    modport host (output sclk, output cs_n, output dc, output reset_n_pin,
                  output host_sda_out, output host_sda_oe, input busy, input sda);
    modport dev  (input sclk, input cs_n, input dc, input reset_n_pin,
                  output dev_sda_out, output dev_sda_oe, output busy, input sda);
endinterface

/* epsp_pkg.sv */
// Purpose: shared constants for the e-paper serial host port (both ends)
// Assumes: one 25 MHz clock per end; link pins pass through an interface
// Notes: Operation list below
//
// Operation
// - serial lines ignored unless select is low
// - 4-wire: data/command high means data
// - reset pin low holds device in reset
// - host sends nothing while busy is high
// - busy high during waveform or sensor traffic
// - strap low 4-wire 8-bit, high 3-wire 9-bit
// - 3-wire: data/command pin unused, held low
// - 4-wire write: sample on rising, msb first
// - host holds data/command steady per byte
// - completed byte routed by data/command level
// - 4-wire read: command, then data/command high
// - read bytes change on falling edge, msb first
// - one or more read bytes; select high ends
// - 3-wire: nine clocks, flag bit then byte
// - 3-wire: flag 1 data, flag 0 command
// - 3-wire read: flag 0, command, flag 1
// - serial clock at most 20/2.5 MHz
package epsp_pkg;
    localparam int          CLK_HZ        = 25000000;
    // 400 ns keeps reads at the 2.5 MHz ceiling; writes could go faster
    localparam int          LINK_PERIOD_NS = 400;
    localparam int          HALF_CLKS     = (LINK_PERIOD_NS * (CLK_HZ / 1000000)) / 2000;
    localparam int          BYTE_BITS     = 8;
    localparam logic [3:0]  BITS_4WIRE    = 4'h8;
    localparam logic [3:0]  BITS_3WIRE    = 4'h9;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          GAP_TICKS     = 2;
    localparam logic [5:0]  PIN_RESET     = 6'h12;  // cs_n, reset_n high; rest low
endpackage

/* epsp_tb.sv */
`timescale 1ns/10ps
// Purpose: bench for host and device ends joined by the link
// Assumes: one 25 MHz clock; inputs move at the falling edge
// Notes: a full receive queue holds the host off through busy
module tb;
    logic       clk = 1'b0, reset = 1'b1, strap = 1'b0, reset_req = 1'b0, cmd_valid = 1'b0;
    logic       cmd_is_data = 1'b0, rx_ready = 1'b0, read_cmd = 1'b0, busy_in = 1'b0;
    logic       overflow_clr = 1'b0, cmd_ready, rd_valid, rx_valid, rx_is_data, tx_next;
    logic       overflow, in_reset;
    logic [7:0] cmd_byte = 8'h00, tx_data = 8'h00, rd_byte, rx_data, last_cmd;
    logic [3:0] rd_count = 4'h0;
    logic [7:0] rd_q[$];
    int         n_errors = 0, n_tests = 0;
    epsp_if lk ();
    epsp_host u_epsp_host (.clk, .reset, .link(lk.host), .mode3(strap), .reset_req,
        .cmd_valid, .cmd_ready, .cmd_is_data, .cmd_byte, .rd_count, .rd_valid, .rd_byte);
    epsp_device u_epsp_device (.clk, .reset, .link(lk.dev), .bus_mode_strap(strap),
        .rx_valid, .rx_ready, .rx_data, .rx_is_data, .last_cmd, .read_cmd, .tx_data,
        .tx_next, .busy_in, .overflow, .overflow_clr, .in_reset);
    epsp_chk u_epsp_chk (.clk, .reset, .bus_mode_strap(strap), .sclk(lk.sclk),
        .cs_n(lk.cs_n), .dc(lk.dc), .reset_n_pin(lk.reset_n_pin), .busy(lk.busy),
        .host_sda_out(lk.host_sda_out), .host_sda_oe(lk.host_sda_oe),
        .dev_sda_out(lk.dev_sda_out), .dev_sda_oe(lk.dev_sda_oe));
    ////////////////////////////////////////
    // clock, read capture and read-back source
    initial forever #20 clk = ~clk;
    always @(negedge clk) if (rd_valid === 1'b1) rd_q.push_back(rd_byte);
    always @(negedge clk) if (tx_next === 1'b1) tx_data = tx_data + 8'h11;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // hold the request until the host takes it
    task automatic send(input logic d, input logic [7:0] b, input logic [3:0] n);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_is_data = d;
        cmd_byte = b;
        rd_count = n;
        for (int i = 0; i < 4000 && cmd_ready !== 1'b1; i++) @(negedge clk);
        chk({7'h00, cmd_ready}, 8'h01);
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    // a fresh edge first, so rx_ready never moves twice in one step
    task automatic take(input logic d, input logic [7:0] b);
        @(negedge clk);
        for (int i = 0; i < 4000 && rx_valid !== 1'b1; i++) @(negedge clk);
        chk({7'h00, rx_valid}, 8'h01);
        chk({7'h00, rx_is_data}, {7'h00, d});
        chk(rx_data, b);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask
    // two-byte read; the command byte itself also lands in the queue
    task automatic rd(input logic [7:0] c);
        read_cmd = 1'b1;
        tx_data = 8'h3C;
        rd_q.delete();
        send(1'b0, c, 4'h2);
        for (int i = 0; i < 4000 && rd_q.size() < 2; i++) @(negedge clk);
        read_cmd = 1'b0;
        chk(8'(rd_q.size()), 8'h02);
        chk(rd_q[0], 8'h3C);
        chk(rd_q[1], 8'h4D);
        take(1'b0, c);
    endtask
    task automatic t_four();
        send(1'b0, 8'h12, 4'h0);
        take(1'b0, 8'h12);
        chk(last_cmd, 8'h12);
        send(1'b1, 8'hA5, 4'h0);
        take(1'b1, 8'hA5);
        rd(8'h2F);
        $display("four-wire done");
    endtask
    // busy from outside, then from a full queue with a request waiting
    task automatic t_busy();
        busy_in = 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h00, lk.busy}, 8'h01);
        chk({7'h00, cmd_ready}, 8'h00);
        busy_in = 1'b0;
        for (int i = 0; i < 16; i++) send(1'b1, 8'h40 + i[7:0], 4'h0);
        fork
            send(1'b1, 8'h7E, 4'h0);
        join_none
        repeat (100) @(negedge clk);
        chk({7'h00, cmd_ready}, 8'h00);
        for (int i = 0; i < 16; i++) take(1'b1, 8'h40 + i[7:0]);
        take(1'b1, 8'h7E);
        chk({7'h00, overflow}, 8'h00);
        $display("busy and fill done");
    endtask
    task automatic t_three();
        reset_req = 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h00, in_reset}, 8'h01);
        reset = 1'b1;
        strap = 1'b1;
        reset_req = 1'b0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        send(1'b0, 8'h5A, 4'h0);
        take(1'b0, 8'h5A);
        send(1'b1, 8'hC3, 4'h0);
        take(1'b1, 8'hC3);
        rd(8'h2E);
        $display("three-wire done");
    endtask
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        t_four();
        t_busy();
        t_three();
        conclude();
    end
    // cut a hang short well past the expected few thousand cycles
    initial begin
        #2000000;
        n_errors++;
        $display("wrong value at %0t: timeout", $time);
        conclude();
    end
endmodule
